// >>> hdl/psm_pkg.sv
/*
 power state manager package: state codes, flag layout, reset values, request codes.
 assumes a single 40 MHz system clock domain.
*/
package psm_pkg;
    localparam int PSM_FLAG_W = 4;
    localparam int PSM_FLAG_SWITCHER_ERR = 0;
    localparam int PSM_FLAG_ACTIVE_BAD_TRANS = 1;
    localparam int PSM_FLAG_SLEEP_BAD_CLOCK = 2;
    localparam int PSM_FLAG_SLEEP_BAD_TRANS = 3;
    localparam logic [3:0] PSM_FLAG_RST = 4'h0;
    localparam logic [3:0] PSM_ENABLE_RST = 4'h0;
    localparam logic PSM_FORCED_RST = 1'b0;
    localparam logic PSM_MODE_LINEAR = 1'b0;
    localparam logic PSM_MODE_SWITCHER = 1'b1;
    localparam logic PSM_LEVEL_ZERO = 1'b0;
    localparam logic PSM_LEVEL_ONE = 1'b1;
    localparam int PSM_SETTLE_NS = 1000;
    localparam int PSM_CLK_MHZ = 40;
    localparam int PSM_SETTLE_CYC = (PSM_SETTLE_NS * PSM_CLK_MHZ) / 1000;
    // requests on i_req_code, taken with i_req_valid
    typedef enum logic [2:0] {
        PSM_REQ_SET_LEVEL,
        PSM_REQ_SET_MODE,
        PSM_REQ_LIGHT_SLEEP,
        PSM_REQ_DEEP_SLEEP_KEEP,
        PSM_REQ_DEEP_SLEEP_DIRECT,
        PSM_REQ_SHUTDOWN
    } psm_req_t;
    // reported power state on o_power_state
    typedef enum logic [2:0] {
        PSM_PS_ACTIVE,
        PSM_PS_LIGHT_SLEEP,
        PSM_PS_DEEP_SLEEP,
        PSM_PS_SHUTDOWN
    } psm_ps_t;
endpackage : psm_pkg

// >>> hdl/psm_power_state_manager.sv
/*
 power state manager: active regulator mode and core level, low-power entry with
 optional state retention, forced entry, four interrupt flags with enable and clear.
 assumes requests come from logic on i_clk; wake-up and clock-busy come from pins.
*/
// Notes on behaviour
// [R01] core level switches either way while active
// [R02] level change keeps regulator mode
// [R03] mode change keeps core level
// [R04] retained deep sleep from switcher goes linear first; direct deep sleep from switcher is refused
// [R05] wake from light sleep or retained deep sleep restores saved mode and level; wake from shutdown does not
// [R06] light sleep, deep sleep, shutdown requested separately
// [R07] direct deep sleep request saves nothing
// [R08] non-forced entry waits for clock requests free; light sleep entry goes straight to sleep without this wait
// [R09] forced entry proceeds, halting busy clocks; light sleep entry never halts clocks
// [R10] by default never cut busy clock source
// [R11] four flags, one mask bit each
// [R12] enable mask write touches selected bits only
// [R13] interrupt only from enabled set flags
// [R14] clear deasserts exactly the masked flags
// [R15] software clears flags early in handler
// [R16] enabled status view beside raw status
// [R17] disallowed request leaves state, sets flag
`timescale 1ns/100ps
module psm_power_state_manager (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req_valid,
    input wire psm_pkg::psm_req_t i_req_code,
    input wire logic i_req_arg,
    input wire logic i_forced_set,
    input wire logic i_forced_clear,
    input wire logic [3:0] i_enable_set,
    input wire logic [3:0] i_enable_clear,
    input wire logic [3:0] i_flag_clear,
    input wire logic i_switcher_fault,
    input wire logic i_clock_busy,
    input wire logic i_wake,
    output logic o_busy,
    output logic o_req_done,
    output logic o_req_ok,
    output psm_pkg::psm_ps_t o_power_state,
    output logic o_regulator_mode,
    output logic o_core_level,
    output logic o_clock_halt,
    output logic o_forced,
    output logic [3:0] o_enable,
    output logic [3:0] o_flags_raw,
    output logic [3:0] o_flags_enabled,
    output logic o_irq
);
    import psm_pkg::*;

    typedef enum logic [2:0] {
        PSM_ST_IDLE,
        PSM_ST_SETTLE,
        PSM_ST_WAIT_CLK,
        PSM_ST_SLEEP,
        PSM_ST_RESTORE
    } psm_st_t;

    typedef struct packed {
        psm_st_t st;
        logic [2:0] sync;
        logic [2:0] wsync;
        logic clk_busy;
        logic wake;
        logic [15:0] cnt;
        psm_req_t req;
        logic mode;
        logic level;
        logic save_mode;
        logic save_level;
        logic restore;
        psm_ps_t ps;
        logic busy;
        logic done;
        logic ok;
        logic halt;
        logic forced;
        logic [3:0] en;
        logic [3:0] flags;
        logic [3:0] flags_en;
        logic irq;
    } psm_state_t;

    psm_state_t s_q;
    psm_state_t s_d;

    function automatic logic psm_agree(input logic [2:0] sh, input logic old);
        psm_agree = (sh[1] == sh[2]) ? sh[2] : old;
    endfunction : psm_agree

    function automatic psm_ps_t psm_sleep_of(input psm_req_t r);
        if (r == PSM_REQ_LIGHT_SLEEP) begin
            psm_sleep_of = PSM_PS_LIGHT_SLEEP;
        end else if (r == PSM_REQ_SHUTDOWN) begin
            psm_sleep_of = PSM_PS_SHUTDOWN;
        end else begin
            psm_sleep_of = PSM_PS_DEEP_SLEEP;
        end
    endfunction : psm_sleep_of

    localparam logic [15:0] SETTLE = 16'(PSM_SETTLE_CYC);

    logic [3:0] set_ev;

    always_comb begin
        s_d = s_q;
        set_ev = 4'h0;
        s_d.done = 1'b0;
        s_d.sync = {s_q.sync[1:0], i_clock_busy};
        s_d.wsync = {s_q.wsync[1:0], i_wake};
        s_d.clk_busy = psm_agree(s_q.sync, s_q.clk_busy);
        s_d.wake = psm_agree(s_q.wsync, s_q.wake);
        set_ev[PSM_FLAG_SWITCHER_ERR] = i_switcher_fault && s_q.mode == PSM_MODE_SWITCHER;
        if (i_forced_set) begin
            s_d.forced = 1'b1;
        end else if (i_forced_clear) begin
            s_d.forced = 1'b0;
        end
        s_d.en = (s_q.en | i_enable_set) & ~i_enable_clear; // [R12]
        case (s_q.st)
            PSM_ST_IDLE: begin
                if (i_req_valid) begin
                    s_d.req = i_req_code;
                    s_d.busy = 1'b1;
                    s_d.restore = 1'b0;
                    case (i_req_code)
                        PSM_REQ_SET_LEVEL: begin
                            s_d.level = i_req_arg; // [R01] [R02]
                            s_d.cnt = SETTLE;
                            s_d.st = PSM_ST_SETTLE;
                        end
                        PSM_REQ_SET_MODE: begin
                            s_d.mode = i_req_arg; // [R03]
                            s_d.cnt = SETTLE;
                            s_d.st = PSM_ST_SETTLE;
                        end
                        PSM_REQ_LIGHT_SLEEP: begin
                            s_d.ps = PSM_PS_LIGHT_SLEEP; // [R06]
                            s_d.save_mode = s_q.mode;
                            s_d.save_level = s_q.level;
                            s_d.restore = 1'b1;
                            s_d.st = PSM_ST_SLEEP;
                        end
                        PSM_REQ_DEEP_SLEEP_KEEP, PSM_REQ_SHUTDOWN: begin
                            s_d.save_mode = s_q.mode;
                            s_d.save_level = s_q.level;
                            s_d.restore = i_req_code == PSM_REQ_DEEP_SLEEP_KEEP; // [R05]
                            s_d.mode = PSM_MODE_LINEAR; // [R04]
                            s_d.cnt = SETTLE;
                            s_d.st = PSM_ST_SETTLE;
                        end
                        PSM_REQ_DEEP_SLEEP_DIRECT: begin
                            if (s_q.mode == PSM_MODE_SWITCHER) begin
                                set_ev[PSM_FLAG_ACTIVE_BAD_TRANS] = 1'b1; // [R17]
                                s_d.busy = 1'b0;
                                s_d.done = 1'b1;
                                s_d.ok = 1'b0;
                            end else begin
                                s_d.st = PSM_ST_WAIT_CLK; // [R07]
                            end
                        end
                        default: begin
                            set_ev[PSM_FLAG_ACTIVE_BAD_TRANS] = 1'b1; // [R17]
                            s_d.busy = 1'b0;
                            s_d.done = 1'b1;
                            s_d.ok = 1'b0;
                        end
                    endcase
                end
            end
            PSM_ST_SETTLE: begin
                if (s_q.cnt > 16'h1) begin
                    s_d.cnt = s_q.cnt - 16'h1;
                end else if (s_q.req == PSM_REQ_SET_LEVEL || s_q.req == PSM_REQ_SET_MODE) begin
                    s_d.st = PSM_ST_IDLE;
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                    s_d.ok = 1'b1;
                end else begin
                    s_d.st = PSM_ST_WAIT_CLK;
                end
            end
            PSM_ST_WAIT_CLK: begin
                if (!s_q.clk_busy || s_q.forced) begin // [R08] [R10]
                    s_d.halt = s_q.clk_busy; // [R09]
                    s_d.ps = psm_sleep_of(s_q.req);
                    s_d.st = PSM_ST_SLEEP;
                end else if (i_req_valid) begin
                    set_ev[PSM_FLAG_SLEEP_BAD_CLOCK] = 1'b1;
                end
            end
            PSM_ST_SLEEP: begin
                if (i_req_valid) begin
                    set_ev[PSM_FLAG_SLEEP_BAD_TRANS] = 1'b1; // [R17]
                end
                if (s_q.wake) begin
                    s_d.halt = 1'b0;
                    s_d.ps = PSM_PS_ACTIVE;
                    if (s_q.restore) begin
                        s_d.mode = s_q.save_mode; // [R05]
                        s_d.level = s_q.save_level;
                        s_d.cnt = SETTLE;
                        s_d.st = PSM_ST_RESTORE;
                    end else begin
                        s_d.st = PSM_ST_IDLE;
                        s_d.busy = 1'b0;
                        s_d.done = 1'b1;
                        s_d.ok = 1'b1;
                    end
                end
            end
            PSM_ST_RESTORE: begin
                if (s_q.cnt > 16'h1) begin
                    s_d.cnt = s_q.cnt - 16'h1;
                end else begin
                    s_d.st = PSM_ST_IDLE;
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                    s_d.ok = 1'b1;
                end
            end
            default: begin
                s_d.st = PSM_ST_IDLE;
            end
        endcase
        s_d.flags = (s_q.flags & ~i_flag_clear) | set_ev; // [R11] [R14]
        s_d.flags_en = s_d.flags & s_d.en; // [R16]
        s_d.irq = |(s_d.flags & s_d.en); // [R13]
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '{st: PSM_ST_IDLE, sync: 3'h0, wsync: 3'h0, clk_busy: 1'b0, wake: 1'b0,
                     cnt: 16'h0, req: PSM_REQ_SET_LEVEL, mode: PSM_MODE_LINEAR,
                     level: PSM_LEVEL_ZERO, save_mode: PSM_MODE_LINEAR,
                     save_level: PSM_LEVEL_ZERO, restore: 1'b0, ps: PSM_PS_ACTIVE,
                     busy: 1'b0, done: 1'b0, ok: 1'b0, halt: 1'b0, forced: PSM_FORCED_RST,
                     en: PSM_ENABLE_RST, flags: PSM_FLAG_RST, flags_en: 4'h0, irq: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_busy = s_q.busy;
    assign o_req_done = s_q.done;
    assign o_req_ok = s_q.ok;
    assign o_power_state = s_q.ps;
    assign o_regulator_mode = s_q.mode;
    assign o_core_level = s_q.level;
    assign o_clock_halt = s_q.halt;
    assign o_forced = s_q.forced;
    assign o_enable = s_q.en;
    assign o_flags_raw = s_q.flags;
    assign o_flags_enabled = s_q.flags_en;
    assign o_irq = s_q.irq;
endmodule : psm_power_state_manager

// >>> testbench/psm_power_state_manager_properties.sv
/*
 checker for the power state manager: port-level relations of requests, flags and states.
 assumes the single i_clk domain and the async active-high i_rst.
*/
`timescale 1ns/100ps
module psm_power_state_manager_properties (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req_valid,
    input wire psm_pkg::psm_req_t i_req_code,
    input wire logic i_req_arg,
    input wire logic [3:0] i_enable_set,
    input wire logic [3:0] i_enable_clear,
    input wire logic [3:0] i_flag_clear,
    input wire logic i_switcher_fault,
    input wire logic o_busy,
    input wire logic o_req_done,
    input wire logic o_req_ok,
    input wire psm_pkg::psm_ps_t o_power_state,
    input wire logic o_regulator_mode,
    input wire logic o_core_level,
    input wire logic o_clock_halt,
    input wire logic o_forced,
    input wire logic [3:0] o_enable,
    input wire logic [3:0] o_flags_raw,
    input wire logic [3:0] o_flags_enabled,
    input wire logic o_irq
);
    import psm_pkg::*;
    default clocking dclk @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    AST_IRQ_OR: assert property (o_irq == |o_flags_enabled)
        else $error("irq is not the or of enabled flags");
    AST_VIEW: assert property (o_flags_enabled == (o_flags_raw & o_enable))
        else $error("enabled flag view wrong");
    AST_EN_MASK: assert property (1'b1 |=> o_enable ==
        (($past(o_enable) | $past(i_enable_set)) & ~$past(i_enable_clear)))
        else $error("enable mask update wrong");
    AST_FLAG_CLR: assert property (i_flag_clear[0] && !i_switcher_fault |=> !o_flags_raw[0])
        else $error("flag not cleared");
    AST_FLAG_KEEP: assert property (o_flags_raw[0] && !i_flag_clear[0] |=> o_flags_raw[0])
        else $error("flag lost without clear");
    AST_FAULT: assert property (i_switcher_fault && o_regulator_mode |=> o_flags_raw[0])
        else $error("switcher fault not flagged");
    AST_LEVEL: assert property (i_req_valid && !o_busy && i_req_code == PSM_REQ_SET_LEVEL
        |=> o_busy && o_core_level == $past(i_req_arg) && $stable(o_regulator_mode))
        else $error("level change wrong");
    AST_MODE: assert property (i_req_valid && !o_busy && i_req_code == PSM_REQ_SET_MODE
        |=> o_busy && o_regulator_mode == $past(i_req_arg) && $stable(o_core_level))
        else $error("mode change wrong");
    AST_SETTLE: assert property (i_req_valid && !o_busy && i_req_code == PSM_REQ_SET_LEVEL
        |-> ##41 o_req_done && o_req_ok)
        else $error("level change not done in time");
    AST_DS_LINEAR: assert property (o_power_state == PSM_PS_DEEP_SLEEP |-> !o_regulator_mode)
        else $error("deep sleep on switcher");
    AST_HALT: assert property ($rose(o_clock_halt) |-> o_forced)
        else $error("clock halted without forcing");
    AST_REFUSE: assert property (i_req_valid && !o_busy && o_regulator_mode
        && i_req_code == PSM_REQ_DEEP_SLEEP_DIRECT |-> ##[1:2] o_req_done && !o_req_ok)
        else $error("direct deep sleep from switcher not refused");
    CV_DEEP: cover property (o_power_state == PSM_PS_DEEP_SLEEP);
    CV_SHUT: cover property (o_clock_halt && o_power_state == PSM_PS_SHUTDOWN);
    CV_IRQ: cover property (o_irq);
endmodule : psm_power_state_manager_properties
bind psm_power_state_manager psm_power_state_manager_properties u_psm_properties (.*);

// >>> testbench/psm_power_state_manager_test.sv
/*
 self-checking bench for the power state manager with a small state model.
 assumes the checker is bound from its own file; inputs change at falling edges.
*/
`timescale 1ns/100ps
module psm_power_state_manager_test;
    import psm_pkg::*;
    logic i_clk, i_rst, i_req_valid, i_req_arg, i_forced_set, i_forced_clear;
    logic i_switcher_fault, i_clock_busy, i_wake, o_busy, o_req_done, o_req_ok;
    logic o_regulator_mode, o_core_level, o_clock_halt, o_forced, o_irq, md, lv;
    logic [3:0] i_enable_set, i_enable_clear, i_flag_clear, o_enable, o_flags_raw;
    logic [3:0] o_flags_enabled;
    logic [7:0] r;
    psm_req_t i_req_code;
    psm_ps_t o_power_state;
    int err_total, n_tests;
    psm_power_state_manager u_psm_power_state_manager (.*);
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    task automatic close_out;
        if (err_total == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string m, input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask : tick
    task automatic issue(input psm_req_t c, input logic a);
        i_req_valid = 1'b1;
        i_req_code = c;
        i_req_arg = a;
        tick(1);
        i_req_valid = 1'b0;
    endtask : issue
    // idle=1 waits for busy low, else for power state p
    task automatic wait_until(input logic idle, input psm_ps_t p);
        int k;
        k = 0;
        while (idle ? o_busy !== 1'b0 : o_power_state !== p) begin
            tick(1);
            k++;
            if (k > 3000) begin
                chk("hang", 1, 0);
                close_out();
            end
        end
    endtask : wait_until
    task automatic chk_state(input psm_ps_t p);
        chk("ps", o_power_state, p);
        chk("mode", o_regulator_mode, md);
        chk("level", o_core_level, lv);
    endtask : chk_state
    task automatic wake_up;
        i_wake = 1'b1;
        tick(6);
        i_wake = 1'b0;
        wait_until(1'b1, PSM_PS_ACTIVE);
    endtask : wake_up
    task automatic sleep_cycle(input psm_req_t c, input psm_ps_t p, input logic halt);
        issue(c, 1'b0);
        wait_until(1'b0, p);
        chk("halt", o_clock_halt, halt);
        wake_up();
    endtask : sleep_cycle
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        {i_req_valid, i_req_arg, i_forced_set, i_forced_clear} = '0;
        {i_switcher_fault, i_clock_busy, i_wake, md, lv} = '0;
        {i_enable_set, i_enable_clear, i_flag_clear} = '0;
        i_req_code = PSM_REQ_SET_LEVEL;
        {err_total, n_tests} = '0;
        r = 8'h3f;
        i_rst = 1'b1;
        tick(3);
        i_rst = 1'b0;
        chk_state(PSM_PS_ACTIVE);
        chk("rst", {o_forced, o_irq, o_enable, o_flags_raw}, 0);
        repeat (10) begin
            r = lfsr(r);
            issue(r[0] ? PSM_REQ_SET_MODE : PSM_REQ_SET_LEVEL, r[1]);
            if (r[0]) md = r[1];
            else lv = r[1];
            wait_until(1'b1, PSM_PS_ACTIVE);
            chk("ok", o_req_ok, 1);
            chk_state(PSM_PS_ACTIVE);
        end
        issue(PSM_REQ_SET_MODE, 1'b1);
        md = 1'b1;
        wait_until(1'b1, PSM_PS_ACTIVE);
        i_switcher_fault = 1'b1;
        tick(1);
        i_switcher_fault = 1'b0;
        issue(PSM_REQ_DEEP_SLEEP_DIRECT, 1'b0);
        tick(2);
        chk("ok", o_req_ok, 0);
        chk_state(PSM_PS_ACTIVE);
        chk("raw", {o_irq, o_flags_raw}, 5'h03);
        i_enable_set = 4'h6;
        tick(1);
        i_enable_set = 4'h0;
        chk("en", {o_irq, o_enable, o_flags_enabled}, 9'h162);
        i_enable_clear = 4'h2;
        tick(1);
        i_enable_clear = 4'h0;
        chk("en", {o_irq, o_enable, o_flags_enabled}, 9'h040);
        i_flag_clear = 4'h2;
        tick(1);
        i_flag_clear = 4'h0;
        chk("raw", o_flags_raw, 4'h1);
        i_clock_busy = 1'b1;
        issue(PSM_REQ_DEEP_SLEEP_KEEP, 1'b0);
        tick(120);
        chk("mode", o_regulator_mode, 0);
        chk("ps", o_power_state, PSM_PS_ACTIVE);
        issue(PSM_REQ_LIGHT_SLEEP, 1'b0);
        i_clock_busy = 1'b0;
        wait_until(1'b0, PSM_PS_DEEP_SLEEP);
        chk("mode", o_regulator_mode, 0);
        issue(PSM_REQ_SET_LEVEL, 1'b1);
        tick(2);
        chk("raw", o_flags_raw, 4'hd);
        wake_up();
        chk_state(PSM_PS_ACTIVE);
        i_forced_set = 1'b1;
        tick(1);
        i_forced_set = 1'b0;
        chk("forced", o_forced, 1);
        i_clock_busy = 1'b1;
        sleep_cycle(PSM_REQ_SHUTDOWN, PSM_PS_SHUTDOWN, 1'b1);
        chk("ps", o_power_state, PSM_PS_ACTIVE);
        i_forced_clear = 1'b1;
        i_clock_busy = 1'b0;
        tick(1);
        i_forced_clear = 1'b0;
        sleep_cycle(PSM_REQ_LIGHT_SLEEP, PSM_PS_LIGHT_SLEEP, 1'b0);
        issue(PSM_REQ_SET_MODE, 1'b0);
        md = 1'b0;
        wait_until(1'b1, PSM_PS_ACTIVE);
        sleep_cycle(PSM_REQ_DEEP_SLEEP_DIRECT, PSM_PS_DEEP_SLEEP, 1'b0);
        chk_state(PSM_PS_ACTIVE);
        close_out();
    end
endmodule : psm_power_state_manager_test
